// ===== rtl/arcc_defs.svh
// Offsets, field positions, reset values and timing counts for the range and clock control
`ifndef ARCC_DEFS_SVH
`define ARCC_DEFS_SVH

`define ARCC_ADDR_W          4
`define ARCC_OFS_CFG1        4'h0
`define ARCC_OFS_CFG2        4'h1
`define ARCC_OFS_CFG4        4'h2
`define ARCC_OFS_CLKCFG      4'h3
`define ARCC_OFS_STATUS      4'h4

`define ARCC_CFG1_SPAN_BIT   0
`define ARCC_CFG1_REFB_BIT   1
`define ARCC_CFG2_EXT_BIT    0
`define ARCC_CFG4_POL_BIT    0
`define ARCC_CLK_SEL_BIT     0
`define ARCC_CLK_DIV_BIT     1
`define ARCC_CLK_LOWSPD_BIT  2
`define ARCC_ST_SAT_BIT      0
`define ARCC_ST_CLKSRC_BIT   1
`define ARCC_ST_HOLD_BIT     2
`define ARCC_ST_SPAN_BIT     3

`define ARCC_CFG_RST         32'h00000000

`define ARCC_CLK_NS          10
`define ARCC_HOLD_US         150
`define ARCC_HOLD_CYC        ((`ARCC_HOLD_US * 1000) / `ARCC_CLK_NS)
`define ARCC_DIV_MAIN        8
`define ARCC_DIV_MOD         2

`endif

// ===== rtl/arcc_pkg.sv
// Types shared by the range and clock control modules
package arcc_pkg;
  typedef enum logic [1:0] {
    ARCC_SRC_INT    = 2'b00,
    ARCC_SRC_HOLD   = 2'b01,
    ARCC_SRC_EXT    = 2'b10
  } arcc_src_e;
  typedef logic [15:0] arcc_word_t;
endpackage : arcc_pkg

// ===== rtl/arcc_code_map.sv
// Output word coding: bipolar or unipolar, standard or extended range
`timescale 1ns/1ps
`include "arcc_defs.svh"
module arcc_code_map
  import arcc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic        sample_valid_in,
  input  wire logic [17:0] sample_in,
  input  wire logic        bipolar_in,
  input  wire logic        extended_in,
  output arcc_word_t       code_out,
  output logic             code_valid_out
);
  // Sample is signed, full scale = +/-2^16 = +/-span
  logic signed [17:0] smp;
  logic signed [19:0] scl;
  logic signed [19:0] bip_w;
  logic signed [19:0] uni_w;
  arcc_word_t         next_code;

  assign smp   = sample_in;
  // Extended range divides by 1.25 (x4/5) so 1.25*span reaches full code
  assign scl   = extended_in ? 20'(((smp * 4) / 5)) : 20'(smp);
  assign bip_w = scl >>> 1;
  assign uni_w = scl;

  function automatic arcc_word_t sat_bip(input logic signed [19:0] v);
    if (v > 20'sd32767)
      sat_bip = 16'h7FFF;
    else if (v < -20'sd32768)
      sat_bip = 16'h8000;
    else
      sat_bip = v[15:0];
  endfunction : sat_bip

  function automatic arcc_word_t sat_uni(input logic signed [19:0] v);
    if (v > 20'sd65535)
      sat_uni = 16'hFFFF;
    else if (v < 20'sd0)
      sat_uni = 16'h0000;
    else
      sat_uni = v[15:0];
  endfunction : sat_uni

  assign next_code = bipolar_in ? sat_bip(bip_w) : sat_uni(uni_w);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      code_out       <= 16'h0000;
      code_valid_out <= 1'b0;
    end else begin
      code_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        code_out <= next_code;
      end
    end
  end

  a_bip_clip: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    sample_valid_in && bipolar_in && (bip_w > 20'sd32767) |=> code_out == 16'h7FFF)
    else $error("bipolar positive clip wrong");
endmodule : arcc_code_map

// ===== rtl/arcc_clk_div.sv
// Master clock derivation: optional divide by eight, then divide by two for the modulator
`timescale 1ns/1ps
`include "arcc_defs.svh"
module arcc_clk_div
  import arcc_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic src_tick_in,
  input  wire logic div8_in,
  output logic      mclk_tick_out,
  output logic      mod_tick_out
);
  logic [2:0] cnt8;
  logic       half;
  logic       next_mclk;

  assign next_mclk = src_tick_in && (!div8_in || cnt8 == 3'h7);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cnt8          <= 3'h0;
      half          <= 1'b0;
      mclk_tick_out <= 1'b0;
      mod_tick_out  <= 1'b0;
    end else begin
      if (src_tick_in)
        cnt8 <= cnt8 + 3'h1;
      if (next_mclk)
        half <= ~half;
      mclk_tick_out <= next_mclk;
      mod_tick_out  <= next_mclk && half;
    end
  end

  a_mod_half: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    mod_tick_out |-> mclk_tick_out && !$past(mod_tick_out))
    else $error("modulator tick not half rate");
endmodule : arcc_clk_div

// ===== rtl/arcc_ctrl.sv
// Range and clock configuration with saturation status over Avalon-MM
//
// How it works
// - Span bit clear gives +/-ref, set gives +/-2*ref.
// - High reference band forces the effective span to 1x.
// - Bipolar coding gives two's complement words with 15 bits per polarity.
// - Unipolar coding accepts 0 to ref and uses all 16 bits.
// - Extended range widens the usable span by 25 percent before clipping.
// - Extended bipolar full-scale codes 7FFF/8000 sit at 1.25 times span times ref.
// - Modulator saturation during a conversion sets the saturation flag.
// - The flag holds for the conversion period and refreshes at the next completion.
// - Master clock is nominally 25.6 MHz high speed and 3.2 MHz low speed.
// - Modulator clock is the master clock divided by two.
// - Clock divide bit divides the external clock by eight.
// - After reset the source select reads zero and the internal oscillator runs.
// - Internal oscillator rate follows the speed mode.
// - Start and reset pins are ignored for 150 us after any source change.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "arcc_defs.svh"
module arcc_ctrl
  import arcc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `ARCC_HOLD_CYC
)(
  input  wire logic                   clk_sys_in,
  input  wire logic                   srst_in,
  // Avalon-MM slave
  input  wire logic [`ARCC_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  // Clock sources: external clock pin level (synchronised here) and oscillator ticks on the system clock
  input  wire logic                   ext_clk_pin_in,
  input  wire logic                   osc_tick_in,
  // Modulator and conversion events
  input  wire logic                   mod_saturated_in,
  input  wire logic                   conv_done_in,
  input  wire logic                   sample_valid_in,
  input  wire logic [17:0]            sample_in,
  // Control pins
  input  wire logic                   start_pin_in,
  input  wire logic                   reset_pin_n_in,
  output logic                        start_out,
  output logic                        ctrl_reset_out,
  // Derived controls
  output logic                        span_2x_out,
  output logic                        osc_low_speed_out,
  output logic                        clk_ext_out,
  output logic                        mclk_tick_out,
  output logic                        mod_tick_out,
  output arcc_word_t                  code_out,
  output logic                        code_valid_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] configuration_register_one;
  logic [31:0] configuration_register_two;
  logic [31:0] configuration_register_four;
  logic [31:0] clock_config;
  logic        modulator_saturation_flag;
  logic        sat_seen;
  arcc_src_e   src_state;
  arcc_src_e   next_src_state;
  logic [14:0] hold_cnt;
  logic        ack;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ext_sy;
  logic [1:0] start_sy;
  logic [1:0] rstn_sy;
  logic       ext_prev;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ext_sy   <= 2'b00;
      start_sy <= 2'b00;
      rstn_sy  <= 2'b11;
      ext_prev <= 1'b0;
    end else begin
      ext_sy   <= {ext_sy[0], ext_clk_pin_in};
      start_sy <= {start_sy[0], start_pin_in};
      rstn_sy  <= {rstn_sy[0], reset_pin_n_in};
      ext_prev <= ext_sy[1];
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        wr_hit     = avs_write_in && !ack;
  wire        rd_hit     = avs_read_in && !ack;
  // Writes land only at the edge where waitrequest is already low
  wire        wr_take    = avs_write_in && ack;
  wire        sel_cfg1   = avs_address_in == `ARCC_OFS_CFG1;
  wire        sel_cfg2   = avs_address_in == `ARCC_OFS_CFG2;
  wire        sel_cfg4   = avs_address_in == `ARCC_OFS_CFG4;
  wire        sel_clk    = avs_address_in == `ARCC_OFS_CLKCFG;
  wire        sel_st     = avs_address_in == `ARCC_OFS_STATUS;
  wire        ext_edge   = ext_sy[1] && !ext_prev;
  wire        span_bit   = configuration_register_one[`ARCC_CFG1_SPAN_BIT];
  wire        refb_bit   = configuration_register_one[`ARCC_CFG1_REFB_BIT];
  wire        clk_sel    = clock_config[`ARCC_CLK_SEL_BIT];
  wire        holding    = src_state == ARCC_SRC_HOLD;
  wire [31:0] status_w;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old_v[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
    be_merge = old_v;
  endfunction : be_merge

  assign span_2x_out       = span_bit && !refb_bit;
  assign osc_low_speed_out = clock_config[`ARCC_CLK_LOWSPD_BIT];
  assign clk_ext_out       = clk_sel;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
  // Control pins are masked while the oscillator settles after a source change
  assign start_out         = start_sy[1] && !holding;
  assign ctrl_reset_out    = !rstn_sy[1] && !holding;
  assign status_w = {28'h0000000, span_2x_out, holding, clk_sel, modulator_saturation_flag};

  // ----------------------------------------------------------------
  // Register writes and one-wait-state handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      configuration_register_one  <= `ARCC_CFG_RST;
      configuration_register_two  <= `ARCC_CFG_RST;
      configuration_register_four <= `ARCC_CFG_RST;
      clock_config                <= `ARCC_CFG_RST;
      ack                         <= 1'b0;
      avs_readdata_out            <= 32'h00000000;
    end else begin
      // Ack drops after one cycle so back-to-back requests each get their wait state
      ack <= wr_hit || rd_hit;
      if (wr_take && sel_cfg1)
        configuration_register_one <= be_merge(configuration_register_one, avs_writedata_in,
                                               avs_byteenable_in) & 32'h00000003;
      if (wr_take && sel_cfg2)
        configuration_register_two <= be_merge(configuration_register_two, avs_writedata_in,
                                               avs_byteenable_in) & 32'h00000001;
      if (wr_take && sel_cfg4)
        configuration_register_four <= be_merge(configuration_register_four, avs_writedata_in,
                                                avs_byteenable_in) & 32'h00000001;
      // Source select is relied on only after the pin already toggles
      if (wr_take && sel_clk)
        clock_config <= be_merge(clock_config, avs_writedata_in,
                                 avs_byteenable_in) & 32'h00000007;
      if (rd_hit) begin
        avs_readdata_out <= sel_cfg1 ? configuration_register_one :
                            sel_cfg2 ? configuration_register_two :
                            sel_cfg4 ? configuration_register_four :
                            sel_clk  ? clock_config :
                            sel_st   ? status_w : 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock source state and settle hold
  // ----------------------------------------------------------------
  // A select written during the hold is taken up when the hold ends
  wire src_change = (src_state == ARCC_SRC_EXT) != clk_sel;

  always_comb begin
    next_src_state = src_state;
    case (src_state)
      ARCC_SRC_INT:  if (src_change) next_src_state = ARCC_SRC_HOLD;
      ARCC_SRC_EXT:  if (src_change) next_src_state = ARCC_SRC_HOLD;
      ARCC_SRC_HOLD: if (hold_cnt == 15'h0001) next_src_state = clk_sel ? ARCC_SRC_EXT : ARCC_SRC_INT;
      default:       next_src_state = ARCC_SRC_INT;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      src_state <= ARCC_SRC_INT;
      hold_cnt  <= 15'h0000;
    end else begin
      src_state <= next_src_state;
      if (src_state != ARCC_SRC_HOLD && src_change)
        hold_cnt <= 15'(HOLD_CYC);
      else if (hold_cnt != 15'h0000)
        hold_cnt <= hold_cnt - 15'h0001;
    end
  end

  // During the hold the outgoing source keeps feeding the divider
  wire use_ext  = (src_state == ARCC_SRC_EXT) || (holding && !clk_sel);
  wire src_tick = use_ext ? ext_edge : osc_tick_in;

  arcc_clk_div u_div (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .src_tick_in   (src_tick),
    .div8_in       (clock_config[`ARCC_CLK_DIV_BIT] && use_ext),
    .mclk_tick_out (mclk_tick_out),
    .mod_tick_out  (mod_tick_out)
  );

  // ----------------------------------------------------------------
  // Saturation flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sat_seen                  <= 1'b0;
      modulator_saturation_flag <= 1'b0;
    end else if (conv_done_in) begin
      // A saturation in the completing cycle still counts
      modulator_saturation_flag <= sat_seen || mod_saturated_in;
      sat_seen                  <= 1'b0;
    end else if (mod_saturated_in) begin
      sat_seen <= 1'b1;
    end
  end

  arcc_code_map u_map (
    .clk_sys_in      (clk_sys_in),
    .srst_in         (srst_in),
    .sample_valid_in (sample_valid_in),
    .sample_in       (sample_in),
    .bipolar_in      (configuration_register_four[`ARCC_CFG4_POL_BIT]),
    .extended_in     (configuration_register_two[`ARCC_CFG2_EXT_BIT]),
    .code_out        (code_out),
    .code_valid_out  (code_valid_out)
  );

  // ----------------------------------------------------------------
  // Settle window length, counted only for the checks below
  // ----------------------------------------------------------------
  // Counting the whole window catches a hold cut short after its first cycles
  logic [14:0] hold_len;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !holding) begin
      hold_len <= 15'h0000;
    end else begin
      hold_len <= hold_len + 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_sel_change;
    !holding ##1 holding;
  endsequence

  sequence s_bus_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence

  a_span_force: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    refb_bit |-> !span_2x_out)
    else $error("span not forced to 1x");
  a_span_sel: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (span_bit && !refb_bit) |-> span_2x_out)
    else $error("2x span not applied");
  a_sat_latch: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !conv_done_in |=> $stable(modulator_saturation_flag))
    else $error("saturation flag changed mid conversion");
  a_sat_set: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (mod_saturated_in && conv_done_in) |=> modulator_saturation_flag)
    else $error("saturation not flagged");
  a_pin_mask: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    s_sel_change |-> (!start_out && !ctrl_reset_out) [*8])
    else $error("control pins not masked");
  a_hold_len: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (src_change && !holding) |=> hold_cnt == 15'(HOLD_CYC))
    else $error("hold length wrong");
  a_rst_src: assert property (@(posedge clk_sys_in)
    srst_in |=> (src_state == ARCC_SRC_INT) && !clk_sel)
    else $error("reset did not select oscillator");
  a_wait_one: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("waitrequest longer than one cycle");
  a_wait_any: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    s_bus_wait |=> !avs_waitrequest_out)
    else $error("waitrequest held past one wait state");
  a_wr_wait: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (avs_write_in && avs_waitrequest_out) |=>
      $stable(configuration_register_one) && $stable(clock_config))
    else $error("write landed while waitrequest high");
  a_rd_stand: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (avs_read_in && !avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved after completion");
  a_sat_clear: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (conv_done_in && !mod_saturated_in && !sat_seen) |=> !modulator_saturation_flag)
    else $error("saturation flag not refreshed");
  a_hold_exit: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (holding && hold_cnt == 15'h0001) |=> !holding)
    else $error("settle hold overran");
  a_hold_full: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $fell(holding) |-> hold_len == 15'(HOLD_CYC))
    else $error("settle hold length wrong");
endmodule : arcc_ctrl

// ===== verif/arcc_clk_source.sv
// Far-side model: external clock pin and internal oscillator ticks
`timescale 1ns/1ps
module arcc_clk_source (
  input  wire logic clk_sys_in,
  input  wire logic ext_run_in,
  output logic      ext_clk_pin_out,
  output logic      osc_tick_out
);
  logic [1:0] div;

  initial begin
    div             = 2'h0;
    ext_clk_pin_out = 1'b0;
    osc_tick_out    = 1'b0;
  end

  // Pin toggles every two system cycles while enabled, stands low otherwise
  always @(posedge clk_sys_in) begin
    div             <= div + 2'h1;
    ext_clk_pin_out <= ext_run_in ? (div[0] ? ~ext_clk_pin_out : ext_clk_pin_out) : 1'b0;
    osc_tick_out    <= (div == 2'h3); // Oscillator runs at a quarter of the system rate
  end
endmodule : arcc_clk_source

// ===== verif/arcc_ctrl_test.sv
// Self-checking testbench for the range and clock control block
`timescale 1ns/1ps
`include "arcc_defs.svh"
module arcc_ctrl_test;
  import arcc_pkg::*;
  typedef struct {logic pol; logic ext; logic [17:0] smp; logic [15:0] code;} arcc_row_s;
  logic clk_sys_in = 1'b0, srst_in = 1'b1, rd = 1'b0, wr = 1'b0, ext_run = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic wreq, ext_pin, osc_tick, sat = 1'b0, done = 1'b0, sv = 1'b0;
  logic start_pin = 1'b1, rst_pin_n = 1'b1, start_o, crst_o, span2x, lowspd, clkext, mclk, modt;
  logic [17:0] smp = 18'h0;
  arcc_word_t code;
  logic cvalid;
  int mismatches = 0, check_count = 0, cycles = 0, mclk_cnt = 0, mod_cnt = 0;
  int m0 = 0, d0 = 0, nm = 0, nd = 0;
  arcc_row_s rows [8] = '{
    '{1'b1, 1'b0, 18'h10000, 16'h7FFF}, '{1'b1, 1'b0, 18'h30000, 16'h8000},
    '{1'b1, 1'b0, 18'h003E8, 16'h01F4}, '{1'b0, 1'b0, 18'h10000, 16'hFFFF},
    '{1'b0, 1'b0, 18'h3FFFB, 16'h0000}, '{1'b1, 1'b1, 18'h13880, 16'h7D00},
    '{1'b1, 1'b1, 18'h2C780, 16'h8300}, '{1'b0, 1'b1, 18'h01388, 16'h0FA0}};

  always #5 clk_sys_in = ~clk_sys_in;

  arcc_clk_source src (.clk_sys_in(clk_sys_in), .ext_run_in(ext_run),
    .ext_clk_pin_out(ext_pin), .osc_tick_out(osc_tick));

  arcc_ctrl #(.HOLD_CYC(20)) dut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .ext_clk_pin_in(ext_pin), .osc_tick_in(osc_tick), .mod_saturated_in(sat),
    .conv_done_in(done), .sample_valid_in(sv), .sample_in(smp),
    .start_pin_in(start_pin), .reset_pin_n_in(rst_pin_n), .start_out(start_o),
    .ctrl_reset_out(crst_o), .span_2x_out(span2x), .osc_low_speed_out(lowspd),
    .clk_ext_out(clkext), .mclk_tick_out(mclk), .mod_tick_out(modt),
    .code_out(code), .code_valid_out(cvalid));

  // ----------------------------------------
  // Run control and shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hung handshake short
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
    if (mclk === 1'b1) mclk_cnt <= mclk_cnt + 1;
    if (modt === 1'b1) mod_cnt <= mod_cnt + 1;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low
  task automatic av_xfer(input logic is_wr, input logic [3:0] a, input logic [31:0] d,
                         input logic [3:0] b);
    addr  <= a;
    wdata <= d;
    be    <= b;
    rd    <= ~is_wr;
    wr    <= is_wr;
    do @(posedge clk_sys_in); while (wreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : av_xfer

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc

  task automatic pulse_conv(input logic s);
    sat  <= s;
    done <= 1'b1;
    @(posedge clk_sys_in);
    sat  <= 1'b0;
    done <= 1'b0;
    cyc(2);
  endtask : pulse_conv

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(4);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    check("clk_ext", 32'h0, clkext);
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("status", 32'h0, got);
    for (int i = 0; i < 4; i++) begin
      av_xfer(1'b1, `ARCC_OFS_CFG1, i, 4'hF);
      check("span_2x", (i == 1), span2x);
      av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
      check("status_span", (i == 1), got[`ARCC_ST_SPAN_BIT]);
    end
    av_xfer(1'b1, `ARCC_OFS_CFG1, 32'h1, 4'h0);
    check("span_no_be", 32'h0, span2x);
    $display("span test done");
    foreach (rows[i]) begin
      av_xfer(1'b1, `ARCC_OFS_CFG4, rows[i].pol, 4'hF);
      av_xfer(1'b1, `ARCC_OFS_CFG2, rows[i].ext, 4'hF);
      smp <= rows[i].smp;
      sv  <= 1'b1;
      @(posedge clk_sys_in);
      sv  <= 1'b0;
      #1;
      check("code_valid", 32'h1, cvalid);
      check("code", rows[i].code, code);
      @(posedge clk_sys_in);
    end
    $display("coding test done");
    sat <= 1'b1;
    @(posedge clk_sys_in);
    sat <= 1'b0;
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("flag_before_done", 32'h0, got[`ARCC_ST_SAT_BIT]);
    pulse_conv(1'b0);
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("flag_set", 32'h1, got[`ARCC_ST_SAT_BIT]);
    pulse_conv(1'b0);
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("flag_refresh", 32'h0, got[`ARCC_ST_SAT_BIT]);
    pulse_conv(1'b1);
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("flag_last_cycle", 32'h1, got[`ARCC_ST_SAT_BIT]);
    pulse_conv(1'b0);
    $display("saturation test done");
    cyc(30);
    m0 = mclk_cnt;
    d0 = mod_cnt;
    cyc(400);
    nm = mclk_cnt - m0;
    nd = mod_cnt - d0;
    check("mclk_int", 32'h1, (nm >= 99 && nm <= 101));
    check("mod_int", 32'h1, (nd * 2 >= nm - 2 && nd * 2 <= nm + 2));
    av_xfer(1'b1, `ARCC_OFS_CLKCFG, 32'h4, 4'hF);
    check("low_speed", 32'h1, lowspd);
    ext_run <= 1'b1;
    cyc(8);
    av_xfer(1'b1, `ARCC_OFS_CLKCFG, 32'h3, 4'hF);
    cyc(1);
    check("start_held", 32'h0, start_o);
    check("clk_ext_set", 32'h1, clkext);
    cyc(10);
    check("start_still_held", 32'h0, start_o);
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("status_hold", 32'h6, got[2:0]);
    cyc(30);
    check("start_free", 32'h1, start_o);
    check("ctrl_reset_idle", 32'h0, crst_o);
    rst_pin_n <= 1'b0;
    cyc(3);
    check("ctrl_reset_pin", 32'h1, crst_o);
    m0 = mclk_cnt;
    d0 = mod_cnt;
    cyc(400);
    nm = mclk_cnt - m0;
    nd = mod_cnt - d0;
    check("mclk_div8", 32'h1, (nm >= 11 && nm <= 14));
    check("mod_div8", 32'h1, (nd * 2 >= nm - 2 && nd * 2 <= nm + 2));
    av_xfer(1'b1, `ARCC_OFS_CLKCFG, 32'h0, 4'hF);
    cyc(17);
    ext_run <= 1'b0;
    check("start_held_back", 32'h0, start_o);
    check("ctrl_reset_held", 32'h0, crst_o);
    rst_pin_n <= 1'b1;
    $display("clock test done");
    av_xfer(1'b1, 4'h7, 32'hFFFFFFFF, 4'hF);
    av_xfer(1'b0, 4'h7, 32'h0, 4'hF);
    check("unmapped", 32'h0, got);
    ext_run <= 1'b1;
    cyc(8);
    av_xfer(1'b1, `ARCC_OFS_CLKCFG, 32'h1, 4'hF);
    srst_in <= 1'b1;
    cyc(2);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    check("clk_ext_rst", 32'h0, clkext);
    av_xfer(1'b0, `ARCC_OFS_STATUS, 32'h0, 4'hF);
    check("src_rst", 32'h0, got[`ARCC_ST_CLKSRC_BIT]);
    $display("reset test done");
    report_and_stop();
  end
endmodule : arcc_ctrl_test
